// >>> hdl/rcs_top.sv
`timescale 1ns/1ps
`include "rcs_defs.svh"

// How it works
// - start-up timer runs on its own, apart from the reset delay counters; the code holds it clear in system reset and whenever no running crystal is targeted
// - no instruction fetch until a valid clock is released after reset
// - clock withheld until the selected source is valid: crystal running and timer expired, pll locked where used
// - clock-fail monitor starts supervising at system reset release
// - invalid source at release falls back to fast internal rc oscillator
// - fallback raises a trap; software may then request the crystal again
// - every register takes a defined value on any reset
// - reset values equal for all reset types except four registers
// - reset-cause register value depends on reset type
// - oscillator control loads from reset type and new-osc config bits
// - rtc calibration and nvm control change only on power-on reset
// - clock-loss trap flag in interrupt control register, zero if none
module rcs_top
	import rcs_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        SYSTEM_RESET_RELEASE,
	input  wire logic [4:0]  RESET_CAUSE_IN,
	input  wire logic [2:0]  NEW_OSC_SELECT_BITS,
	input  wire logic        CLOCK_FAIL_MONITOR_EN,
	input  wire logic        OSC_RUNNING,
	input  wire logic        PLL_LOCKED,
	output logic             CPU_CLK_EN,
	output logic      [2:0]  SYS_CLK_SEL,
	output logic             TRAP_REQ,
	output logic             IRQ
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int SW = 12;

	logic [SW-1:0] sync_a;
	logic [SW-1:0] sync_b;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {SYSTEM_RESET_RELEASE, RESET_CAUSE_IN, NEW_OSC_SELECT_BITS,
				CLOCK_FAIL_MONITOR_EN, OSC_RUNNING, PLL_LOCKED};
			sync_b <= sync_a;
		end
	end

	wire       sys_rel   = sync_b[11];
	wire [4:0] cause_in  = sync_b[10:6];
	wire [2:0] nosc_cfg  = sync_b[5:3];
	wire       clock_fail_monitor_en   = sync_b[2];
	wire       osc_run   = sync_b[1];
	wire       pll_lock  = sync_b[0];

	// ----------------------------------------
	// source validity
	// ----------------------------------------
	function automatic logic needs_xtal(input rcs_osc_t c);
		return (c == `RCS_OSC_XTAL) || (c == `RCS_OSC_XTALPLL);
	endfunction : needs_xtal

	function automatic logic uses_pll(input rcs_osc_t c);
		return (c == `RCS_OSC_FRCPLL) || (c == `RCS_OSC_XTALPLL);
	endfunction : uses_pll

	function automatic logic src_valid(input rcs_osc_t c, input logic run,
		input logic ost_ok, input logic lock);
		return (!needs_xtal(c) || (run && ost_ok)) && (!uses_pll(c) || lock);
	endfunction : src_valid

	// ----------------------------------------
	// state and registers
	// ----------------------------------------
	rcs_state_e state;
	rcs_state_e next_state;
	logic       por_pending;
	logic [4:0] cause;
	rcs_osc_t   osc_cur;
	rcs_osc_t   osc_new;
	logic       sw_req;
	logic       failed;
	logic [15:0] rtccal;
	logic [15:0] nvmctl;
	logic       osc_flt;
	logic [2:0] status;
	logic [2:0] mask;
	logic [9:0] ost_cnt;

	localparam logic [9:0] OST_LAST = 10'(`RCS_OST_CYCLES);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire acc     = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	wire wr_do   = AVS_WRITE && !AVS_WAITREQUEST;
	wire hold    = (state == ST_HOLD);
	wire wr_ok   = wr_do && !hold;
	wire wr_osc  = wr_ok && (AVS_ADDRESS == `RCS_OFS_OSCCTL);
	wire wr_rtc  = wr_ok && (AVS_ADDRESS == `RCS_OFS_RTCCAL);
	wire wr_nvm  = wr_ok && (AVS_ADDRESS == `RCS_OFS_NVMCTL);
	wire wr_int  = wr_ok && (AVS_ADDRESS == `RCS_OFS_INTCTL1);
	wire wr_sts  = wr_ok && (AVS_ADDRESS == `RCS_OFS_STATUS);
	wire wr_msk  = wr_ok && (AVS_ADDRESS == `RCS_OFS_MASK);
	wire wr_cau  = wr_ok && (AVS_ADDRESS == `RCS_OFS_CAUSE);

	// ----------------------------------------
	// start-up timer
	// ----------------------------------------
	wire       switching = (state == ST_SWITCH);
	rcs_osc_t  target;
	assign target = switching ? osc_new : osc_cur;
	wire ost_ok   = (ost_cnt == OST_LAST);
	wire restart  = hold || (state == ST_RUN && sw_req);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			ost_cnt <= '0;
		else if (restart || !osc_run || !needs_xtal(target))
			ost_cnt <= '0;
		else if (!ost_ok)
			ost_cnt <= ost_cnt + 10'h001;
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	wire cur_ok  = src_valid(osc_cur, osc_run, ost_ok, pll_lock);
	wire new_ok  = src_valid(osc_new, osc_run, ost_ok, pll_lock);
	wire mon_on  = clock_fail_monitor_en && !hold;
	wire cur_ok_at_rel = src_valid(nosc_cfg, osc_run, 1'b0, pll_lock);
	wire fall_rel = hold && sys_rel && clock_fail_monitor_en && !cur_ok_at_rel;
	wire fall_run = mon_on && (state != ST_WAIT) && !cur_ok;
	wire fallback = fall_rel || fall_run;
	wire sw_done  = switching && new_ok && !fall_run;

	always_comb begin
		next_state = state;
		case (state)
			ST_HOLD:
				if (sys_rel)
					next_state = fall_rel ? ST_RUN : ST_WAIT;
			ST_WAIT:
				if (cur_ok)
					next_state = ST_RUN;
			ST_RUN:
				if (fall_run)
					next_state = ST_RUN;
				else if (sw_req)
					next_state = ST_SWITCH;
			ST_SWITCH:
				if (fall_run || sw_done)
					next_state = ST_RUN;
			default:
				next_state = ST_HOLD;
		endcase
		if (!sys_rel)
			next_state = ST_HOLD;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state       <= ST_HOLD;
			por_pending <= 1'b1;
		end else begin
			state       <= next_state;
			por_pending <= por_pending && hold;
		end
	end

	// ----------------------------------------
	// reset-dependent registers
	// ----------------------------------------
	// defined values on any reset
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			cause <= `RCS_CAUSE_RST;
		else if (hold)
			cause <= cause | cause_in;
		else if (wr_cau)
			cause <= AVS_WRITEDATA[4:0];
	end

	// osc control from config and type
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			osc_cur <= `RCS_OSC_FRC;
			osc_new <= `RCS_OSC_FRC;
			sw_req  <= 1'b0;
			failed  <= 1'b0;
		end else if (hold) begin
			osc_cur <= fall_rel ? `RCS_OSC_FRC : nosc_cfg;
			osc_new <= nosc_cfg;
			sw_req  <= 1'b0;
			// fail history survives all but power-on
			failed  <= fall_rel || (failed && !por_pending);
		end else begin
			if (fallback) begin
				osc_cur <= `RCS_OSC_FRC;
				failed  <= 1'b1;
			end else if (sw_done) begin
				osc_cur <= osc_new;
			end
			if (wr_osc && !switching) begin
				osc_new <= AVS_WRITEDATA[`RCS_OSC_NEW_LSB +: 3];
				sw_req  <= AVS_WRITEDATA[`RCS_OSC_SWREQ];
			end else if (sw_done || fallback) begin
				sw_req  <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rtccal <= `RCS_RTCCAL_RST;
			nvmctl <= `RCS_NVMCTL_RST;
		end else begin
			if (wr_rtc)
				rtccal <= AVS_WRITEDATA[15:0];
			if (wr_nvm)
				nvmctl <= AVS_WRITEDATA[15:0];
		end
	end

	// ----------------------------------------
	// trap flag and interrupts
	// ----------------------------------------
	wire [2:0] events = {sw_done, fallback,
		(state == ST_WAIT) && cur_ok && sys_rel};

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			osc_flt <= 1'b0;
			status  <= '0;
			mask    <= `RCS_MASK_RST;
		end else if (hold) begin
			osc_flt <= fall_rel;
			status  <= {1'b0, fall_rel, 1'b0};
			mask    <= `RCS_MASK_RST;
		end else begin
			if (fallback)
				osc_flt <= 1'b1;
			else if (wr_int)
				osc_flt <= AVS_WRITEDATA[`RCS_INT_OSCFLT];
			status <= events | (status & ~(wr_sts ? AVS_WRITEDATA[2:0] : 3'h0));
			if (wr_msk)
				mask <= AVS_WRITEDATA[2:0];
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (AVS_ADDRESS)
			`RCS_OFS_CAUSE:   rd_mux[4:0] = cause;
			`RCS_OFS_OSCCTL: begin
				rd_mux[`RCS_OSC_CUR_LSB +: 3] = osc_cur;
				rd_mux[`RCS_OSC_NEW_LSB +: 3] = osc_new;
				rd_mux[`RCS_OSC_SWREQ]        = sw_req;
				rd_mux[`RCS_OSC_FAILED]       = failed;
			end
			`RCS_OFS_RTCCAL:  rd_mux[15:0] = rtccal;
			`RCS_OFS_NVMCTL:  rd_mux[15:0] = nvmctl;
			`RCS_OFS_INTCTL1: rd_mux[`RCS_INT_OSCFLT] = osc_flt;
			`RCS_OFS_STATUS:  rd_mux[2:0] = status;
			`RCS_OFS_MASK:    rd_mux[2:0] = mask;
			`RCS_OFS_SEQ:     rd_mux[1:0] = state;
			default:          rd_mux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// bus slave and outputs
	// ----------------------------------------
	// one wait cycle keeps read data registered
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
		end else begin
			AVS_WAITREQUEST <= !acc;
			if (acc && AVS_READ)
				AVS_READDATA <= rd_mux;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			CPU_CLK_EN  <= 1'b0;
			SYS_CLK_SEL <= `RCS_OSC_FRC;
			TRAP_REQ    <= 1'b0;
			IRQ         <= 1'b0;
		end else begin
			CPU_CLK_EN  <= (next_state == ST_RUN) || (next_state == ST_SWITCH);
			SYS_CLK_SEL <= hold ? `RCS_OSC_FRC : osc_cur;
			TRAP_REQ    <= fallback;
			IRQ         <= |(status & mask);
		end
	end

endmodule : rcs_top

// >>> hdl/rcs_defs.svh
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define RCS_OFS_CAUSE    4'h0
`define RCS_OFS_OSCCTL   4'h1
`define RCS_OFS_RTCCAL   4'h2
`define RCS_OFS_NVMCTL   4'h3
`define RCS_OFS_INTCTL1  4'h4
`define RCS_OFS_STATUS   4'h5
`define RCS_OFS_MASK     4'h6
`define RCS_OFS_SEQ      4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define RCS_CAUSE_POR    0
`define RCS_OSC_CUR_LSB  0
`define RCS_OSC_NEW_LSB  4
`define RCS_OSC_SWREQ    8
`define RCS_OSC_FAILED   9
`define RCS_INT_OSCFLT   1
`define RCS_EVT_RELEASE  0
`define RCS_EVT_FAIL     1
`define RCS_EVT_SWDONE   2

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RCS_CAUSE_RST    5'h01
`define RCS_RTCCAL_RST   16'h0000
`define RCS_NVMCTL_RST   16'h0000
`define RCS_MASK_RST     3'h0
`define RCS_OSC_FRC      3'h0
`define RCS_OSC_FRCPLL   3'h1
`define RCS_OSC_XTAL     3'h2
`define RCS_OSC_XTALPLL  3'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define RCS_CLK_PERIOD_NS 4
`define RCS_OST_TIME_NS   2000
`define RCS_OST_CYCLES    ((`RCS_OST_TIME_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)

`endif

// >>> hdl/rcs_pkg.sv
package rcs_pkg;
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_WAIT,
		ST_RUN,
		ST_SWITCH
	} rcs_state_e;

	typedef logic [2:0] rcs_osc_t;
endpackage : rcs_pkg

// >>> dv/rcs_osc_model.sv
`timescale 1ns/1ps
// --
// crystal and pll stand-in
// --
module rcs_osc_model (
	input  wire logic clk,
	input  wire logic on,
	input  wire logic slow,
	output logic      running,
	output logic      locked
);
	int cnt = 0;
	// slow start mimics a low-frequency crystal
	always @(posedge clk)
		cnt <= on ? cnt + 1 : 0;
	assign running = on && cnt > (slow ? 200 : 20);
	assign locked = on && cnt > (slow ? 230 : 40);
endmodule : rcs_osc_model

// >>> dv/rcs_top_assertions.sv
`timescale 1ns/1ps
// --
// port checks
// --
module rcs_top_assertions (
	input wire logic       CLK,
	input wire logic       NRST,
	input wire logic       AVS_READ,
	input wire logic       AVS_WRITE,
	input wire logic       AVS_WAITREQUEST,
	input wire logic       SYSTEM_RESET_RELEASE,
	input wire logic       CLOCK_FAIL_MONITOR_EN,
	input wire logic       OSC_RUNNING,
	input wire logic       CPU_CLK_EN,
	input wire logic [2:0] SYS_CLK_SEL,
	input wire logic       TRAP_REQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_wait_one_cycle: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
		else $error("wait low too long");
	a_req_answered: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|-> ##[1:2] !AVS_WAITREQUEST) else $error("no answer");
	a_hold_no_clk: assert property (!SYSTEM_RESET_RELEASE [*4] |-> !CPU_CLK_EN)
		else $error("clock in hold");
	a_clk_after_rel: assert property (CPU_CLK_EN |-> $past(SYSTEM_RESET_RELEASE, 3))
		else $error("clock before release");
	a_xtal_running: assert property ($rose(SYS_CLK_SEL[1] && CPU_CLK_EN) |-> $past(OSC_RUNNING, 3))
		else $error("crystal not running");
	a_trap_pulse: assert property (TRAP_REQ |=> !TRAP_REQ)
		else $error("trap too long");
	a_trap_frc: assert property (TRAP_REQ |-> ##[0:2] (SYS_CLK_SEL == 3'h0 && CPU_CLK_EN))
		else $error("no fallback");
	a_trap_mon: assert property (TRAP_REQ |-> $past(CLOCK_FAIL_MONITOR_EN, 3))
		else $error("trap without monitor");
	c_trap: cover property (TRAP_REQ);
	c_clk_on: cover property ($rose(CPU_CLK_EN));
	c_xtal: cover property ($rose(SYS_CLK_SEL[1]));
endmodule : rcs_top_assertions

bind rcs_top rcs_top_assertions chk (.CLK(CLK), .NRST(NRST), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.SYSTEM_RESET_RELEASE(SYSTEM_RESET_RELEASE), .CLOCK_FAIL_MONITOR_EN(CLOCK_FAIL_MONITOR_EN),
	.OSC_RUNNING(OSC_RUNNING), .CPU_CLK_EN(CPU_CLK_EN), .SYS_CLK_SEL(SYS_CLK_SEL),
	.TRAP_REQ(TRAP_REQ));

// >>> dv/rcs_top_tb.sv
`timescale 1ns/1ps
// --
// bench
// --
module rcs_top_tb;
	logic        clk = 0, nrst = 0, rd_en = 0, wr_en = 0, rel = 0, mon = 0, osc_on = 0, slow = 1;
	logic [3:0]  addr = 0;
	logic [31:0] wdata = 0, rdata, q;
	logic [4:0]  cause_in = 0;
	logic [2:0]  cfg = 0, sel;
	logic        wreq, clk_en, trap, irq, running, locked;
	int          fails = 0, tests_run = 0, cyc = 0, traps = 0, seed = 75429, m_cause, m_rtc;
	always #2 clk = ~clk;
	rcs_top uut (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .SYSTEM_RESET_RELEASE(rel), .RESET_CAUSE_IN(cause_in),
		.NEW_OSC_SELECT_BITS(cfg), .CLOCK_FAIL_MONITOR_EN(mon), .OSC_RUNNING(running),
		.PLL_LOCKED(locked), .CPU_CLK_EN(clk_en), .SYS_CLK_SEL(sel), .TRAP_REQ(trap), .IRQ(irq));
	rcs_osc_model osc (.clk(clk), .on(osc_on), .slow(slow), .running(running), .locked(locked));
	task stop_test;
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// a run needs some 1500 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (trap)
			traps <= traps + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata;
		chk(wreq, 0);
		rd_en <= 0;
		wr_en <= 0;
		@(posedge clk);
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(0, a, 0);
		chk(q & m, e);
	endtask : rd
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task wait_en(input logic [2:0] s);
		int n;
		n = 0;
		while ((clk_en !== 1'b1 || sel !== s) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk({clk_en, sel}, {1'b1, s});
	endtask : wait_en
	initial begin
		wt(4);
		nrst <= 1;
		wt(2);
		rd(0, '1, 1);
		rd(2, '1, 0);
		rd(4, '1, 0);
		rd(6, '1, 0);
		rd(4'hc, '1, 0);
		rel <= 1;
		wait_en(0);
		rd(7, '1, 2);
		rd(5, 1, 1);
		m_rtc = $random(seed) & 16'hffff;
		m_cause = $random(seed) & 5'h1f;
		bus(1, 2, m_rtc);
		bus(1, 3, m_cause);
		rel <= 0;
		cfg <= 2;
		cause_in <= m_cause[4:0];
		wt(8);
		rd(0, '1, m_cause | 1);
		rd(2, '1, m_rtc);
		rd(3, '1, m_cause);
		rd(1, 32'h70, 32'h20);
		cause_in <= 0;
		rel <= 1;
		wt(100);
		chk(clk_en, 0);
		rd(7, '1, 1);
		osc_on <= 1;
		wait_en(2);
		// crystal is never valid at release, so monitor must fall back
		rel <= 0;
		cfg <= 3;
		mon <= 1;
		slow <= 0;
		wt(8);
		rel <= 1;
		wt(12);
		chk(traps, 1);
		chk({clk_en, sel}, 4'h8);
		rd(4, 2, 2);
		rd(1, 32'h200, 32'h200);
		bus(1, 6, 2);
		wt(2);
		chk(irq, 1);
		bus(1, 5, 2);
		wt(2);
		chk(irq, 0);
		bus(1, 1, 32'h120);
		wait_en(2);
		rd(5, 4, 4);
		// crystal dies while running: monitor must fall back again
		osc_on <= 0;
		wt(8);
		chk(traps, 2);
		chk({clk_en, sel}, 4'h8);
		nrst <= 0;
		wt(2);
		nrst <= 1;
		wt(2);
		rd(2, '1, 0);
		rd(3, '1, 0);
		stop_test();
	end
endmodule : rcs_top_tb
